//--- hw/ucf_core.sv
// ucf_core: serial port core with wishbone registers, transmitter, receiver
`timescale 1ns/10ps
module ucf_core (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [4:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// serial pins
	input wire logic serial_in_pin_i,
	output logic serial_out_pin_o,
	input wire logic transfer_clock_pin_i,
	output logic transfer_clock_pin_o,
	output logic transfer_clock_pin_oe_o
);
	import ucf_pkg::*;

	typedef struct packed {
		logic ack;
		logic [7:0] dat;
		logic reload;
		logic [DIV_W-1:0] div;
		logic dbl;
		logic prr;
		logic dir;
		logic rxen;
		logic txen;
		logic [2:0] csz;
		logic tx8;
		logic sync;
		logic [1:0] pm;
		logic sbs;
		logic pol;
		logic [8:0] txb;
		logic txb_v;
		logic txc;
		logic tx_busy;
		logic [12:0] tx_sh;
		logic [3:0] tx_cnt;
		logic [3:0] tx_pre;
		logic xck;
		logic rx_busy;
		logic [3:0] rx_os;
		logic [3:0] rx_idx;
		logic [8:0] rx_sh;
		logic rx_par;
		logic [1:0][10:0] fifo;
		logic [1:0] f_cnt;
		logic f_rd;
		logic dor;
	} ucf_core_s;
	ucf_core_s s_q, s_d;

	ucf_clk_if cif ();

	ucf_baud_gen u_baud (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cif(cif.gen)
	);

	ucf_xck_sync u_xsync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.xck_i(transfer_clock_pin_i),
		.cif(cif.sync)
	);

	// whole frame image, start bit in bit 0
	function automatic logic [12:0] ucf_frame(input logic [8:0] d, input logic [3:0] n,
			input logic [1:0] pm);
		logic [12:0] f;
		logic p;
		f = '1;
		f[0] = 1'b0;
		p = pm[0];
		for (int i = 0; i < 9; i++) begin
			if (4'(i) < n) begin
				f[i+1] = d[i];
				p = p ^ d[i];
			end
		end
		if (pm[1]) begin
			f[n+4'h1] = p;
		end
		return f;
	endfunction : ucf_frame

	logic [3:0] nbits;
	logic pen;
	logic master;
	logic e_rise;
	logic e_fall;
	logic chg;
	logic smp;
	logic tx_bit;
	logic rx_smp;
	logic req;
	logic acc;
	logic wr;
	logic [10:0] head;
	logic [7:0] rdata;
	logic run_tx;
	logic run_rx;

	// shared frame settings and mode decode
	assign nbits = ucf_nbits(s_q.csz);
	assign pen = s_q.pm[1];
	assign master = s_q.sync & s_q.dir;
	assign run_tx = s_q.txen & ~s_q.prr;
	assign run_rx = s_q.rxen & ~s_q.prr;
	assign head = s_q.fifo[s_q.f_rd];

	// clock edges: own clock in master, pin edges in slave
	always_comb begin
		if (master) begin
			e_rise = cif.baud_tick & ~s_q.xck;
			e_fall = cif.baud_tick & s_q.xck;
		end else begin
			e_rise = s_q.sync & cif.xck_rise;
			e_fall = s_q.sync & cif.xck_fall;
		end
	end
	assign chg = s_q.pol ? e_fall : e_rise;
	assign smp = s_q.pol ? e_rise : e_fall;

	// transmit bit strobe per mode
	assign tx_bit = s_q.sync ? chg : (cif.baud_tick &&
		s_q.tx_pre == (s_q.dbl ? OS_DBL_LAST : OS_NORM_LAST));
	// receive sample strobe per mode
	assign rx_smp = s_q.rx_busy & (s_q.sync ? smp :
		(cif.baud_tick && s_q.rx_os == 4'h0));

	// bus decode
	assign req = cyc_i & stb_i;
	assign acc = req & s_q.ack;
	assign wr = acc & we_i & sel_i[0];
	assign ack_o = s_q.ack;
	assign dat_o = {24'h000000, s_q.dat};
	assign cif.divisor = s_q.div;
	assign cif.reload = s_q.reload;

	// pins
	assign serial_out_pin_o = s_q.tx_sh[0];
	assign transfer_clock_pin_o = s_q.xck;
	assign transfer_clock_pin_oe_o = master & ~s_q.prr;

	// read mux
	always_comb begin
		rdata = 8'h00;
		case (adr_i)
			ADR_DATA: rdata = head[7:0];
			ADR_LINE: begin
				rdata[LS_RXC] = (s_q.f_cnt != 2'h0);
				rdata[LS_TXC] = s_q.txc;
				rdata[LS_EMPTY] = ~s_q.txb_v;
				rdata[LS_FE] = head[9];
				rdata[LS_DOR] = s_q.dor;
				rdata[LS_PE] = head[10];
				rdata[LS_DBL] = s_q.dbl;
			end
			ADR_ENAB: begin
				rdata[EN_PRR] = s_q.prr;
				rdata[EN_DIR] = s_q.dir;
				rdata[EN_RX] = s_q.rxen;
				rdata[EN_TX] = s_q.txen;
				rdata[EN_CSZ2] = s_q.csz[2];
				rdata[EN_RX8] = head[8];
				rdata[EN_TX8] = s_q.tx8;
			end
			ADR_FRAME: begin
				rdata[FC_SYNC] = s_q.sync;
				rdata[FC_PM_HI:FC_PM_LO] = s_q.pm;
				rdata[FC_SBS] = s_q.sbs;
				rdata[FC_CSZ_HI:FC_CSZ_LO] = s_q.csz[1:0];
				rdata[FC_POL] = s_q.pol;
			end
			ADR_DIVL: rdata = s_q.div[7:0];
			ADR_DIVH: rdata = {4'h0, s_q.div[11:8]};
			default: rdata = 8'h00;
		endcase
	end

	// next state
	always_comb begin
		logic [10:0] ent;
		logic push;
		ent = '0;
		push = 1'b0;
		s_d = s_q;

		// bus handshake, one wait cycle then ack
		s_d.ack = req & ~s_q.ack;
		s_d.reload = 1'b0;
		if (req && !s_q.ack) begin
			s_d.dat = rdata;
		end

		// register writes
		if (wr) begin
			case (adr_i)
				ADR_DATA: begin
					s_d.txb = {s_q.tx8, dat_i[7:0]};
					s_d.txb_v = 1'b1;
				end
				ADR_LINE: begin
					if (dat_i[LS_TXC]) begin
						s_d.txc = 1'b0;
					end
					s_d.dbl = dat_i[LS_DBL];
				end
				ADR_ENAB: begin
					s_d.prr = dat_i[EN_PRR];
					s_d.dir = dat_i[EN_DIR];
					s_d.rxen = dat_i[EN_RX];
					s_d.txen = dat_i[EN_TX];
					s_d.csz[2] = dat_i[EN_CSZ2];
					s_d.tx8 = dat_i[EN_TX8];
				end
				ADR_FRAME: begin
					s_d.sync = dat_i[FC_SYNC];
					s_d.pm = dat_i[FC_PM_HI:FC_PM_LO];
					s_d.sbs = dat_i[FC_SBS];
					s_d.csz[1:0] = dat_i[FC_CSZ_HI:FC_CSZ_LO];
					s_d.pol = dat_i[FC_POL];
				end
				ADR_DIVL: begin
					s_d.div[7:0] = dat_i[7:0];
					s_d.reload = 1'b1;
				end
				ADR_DIVH: s_d.div[11:8] = dat_i[3:0];
				default: ;
			endcase
		end

		// data read pops the receive buffer, clears overrun
		if (acc && !we_i && adr_i == ADR_DATA && s_q.f_cnt != 2'h0) begin
			s_d.f_cnt = s_q.f_cnt - 2'h1;
			s_d.f_rd = ~s_q.f_rd;
			s_d.dor = 1'b0;
		end

		// internal transfer clock, toggled per baud pulse while the pin is driven;
		// it holds otherwise so the pin never moves while undriven
		if (master && !s_q.prr) begin
			s_d.xck = s_q.xck ^ cif.baud_tick;
		end


		// transmit prescaler
		if (s_q.sync || !run_tx) begin
			s_d.tx_pre = 4'h0;
		end else if (cif.baud_tick) begin
			s_d.tx_pre = tx_bit ? 4'h0 : s_q.tx_pre + 4'h1;
		end

		// transmit shifter
		if (!run_tx) begin
			s_d.tx_busy = 1'b0;
			s_d.tx_sh = '1;
		end else if (tx_bit) begin
			if (s_q.tx_busy && s_q.tx_cnt > 4'h1) begin
				s_d.tx_sh = {1'b1, s_q.tx_sh[12:1]};
				s_d.tx_cnt = s_q.tx_cnt - 4'h1;
			end else if (s_q.txb_v) begin
				s_d.tx_sh = ucf_frame(s_q.txb, nbits, s_q.pm);
				s_d.tx_cnt = nbits + 4'h2 + {3'h0, pen} + {3'h0, s_q.sbs};
				s_d.tx_busy = 1'b1;
				s_d.txb_v = wr && adr_i == ADR_DATA;
			end else if (s_q.tx_busy) begin
				s_d.tx_busy = 1'b0;
				s_d.tx_sh = '1;
				s_d.txc = 1'b1;
			end
		end

		// receiver
		if (!run_rx) begin
			s_d.rx_busy = 1'b0;
		end else if (!s_q.rx_busy) begin
			if (s_q.sync && smp && !serial_in_pin_i) begin
				s_d.rx_busy = 1'b1;
				s_d.rx_idx = 4'h1;
				s_d.rx_par = 1'b0;
			end else if (!s_q.sync && cif.baud_tick && !serial_in_pin_i) begin
				s_d.rx_busy = 1'b1;
				s_d.rx_idx = 4'h0;
				s_d.rx_par = 1'b0;
				s_d.rx_os = s_q.dbl ? OS_DBL_HALF : OS_NORM_HALF;
			end
		end else if (rx_smp) begin
			s_d.rx_os = s_q.dbl ? OS_DBL_LAST : OS_NORM_LAST;
			if (s_q.rx_idx == 4'h0) begin
				s_d.rx_busy = ~serial_in_pin_i;
				s_d.rx_idx = 4'h1;
			end else if (s_q.rx_idx <= nbits) begin
				s_d.rx_sh = {serial_in_pin_i, s_q.rx_sh[8:1]};
				s_d.rx_par = s_q.rx_par ^ serial_in_pin_i;
				s_d.rx_idx = s_q.rx_idx + 4'h1;
			end else if (pen && s_q.rx_idx == nbits + 4'h1) begin
				s_d.rx_par = s_q.rx_par ^ serial_in_pin_i;
				s_d.rx_idx = s_q.rx_idx + 4'h1;
			end else begin
				// first stop bit ends the frame, second is never checked
				s_d.rx_busy = 1'b0;
				push = 1'b1;
				ent[8:0] = s_q.rx_sh >> (DATA_MAX - nbits);
				ent[9] = ~serial_in_pin_i;
				ent[10] = pen & (s_q.rx_par ^ s_q.pm[0]);
			end
		end else if (!s_q.sync && cif.baud_tick) begin
			s_d.rx_os = s_q.rx_os - 4'h1;
		end

		// two-deep receive buffer, overrun when full
		if (push) begin
			if (s_d.f_cnt == 2'h2) begin
				s_d.dor = 1'b1;
			end else begin
				s_d.fifo[s_d.f_rd ^ s_d.f_cnt[0]] = ent;
				s_d.f_cnt = s_d.f_cnt + 2'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
			s_q.csz <= CSZ_RST;
			s_q.div <= DIV_RST;
			s_q.tx_sh <= '1;
		end else begin
			s_q <= s_d;
		end
	end
endmodule : ucf_core

//--- hw/ucf_pkg.sv
// ucf_pkg: constants shared by the serial port clock and frame core
// Function
// - four clock modes; sync mode select picks asynchronous or synchronous
// - in sync mode, clock direction output means master, input means slave
// - divisor counter counts down, reloads at zero or low write, pulses per zero
// - transmit bit rate is baud pulses over 16, 8 or 2 by mode
// - receiver uses baud pulses directly with 2, 8 or 16 states per bit
// - divisor is 12 bits split over high and low registers
// - double speed acts only in async; software keeps it clear in sync
// - double speed receiver counts 8 baud pulses per bit instead of 16, sampling once
// - slave clock is synchronised and edge detected; keep below clock over 4
// - in sync mode receive samples on the edge opposite transmit change
// - polarity clear: change on rising, sample falling; set swaps the edges
// - transfer clock pin is driven or used only in synchronous mode
// - all 30 frames: start, 5 to 9 data, no/even/odd parity, 1 or 2 stops
// - frame order: start, data LSB first, optional parity, stop bits
// - start bit low, stop bits high, line idles high between frames
// - transmitter and receiver share size and parity settings; the stop setting is used by the transmitter only
// - receiver checks only first stop bit; frame error when it is zero
// - parity is XOR of data for even, inverted XOR for odd
// - receiver reports frame error, overrun and parity error
// - one transmit buffer word for gapless frames; two-deep receive buffer
// - parity enable bit set inserts parity between last data and first stop
package ucf_pkg;
	// register byte addresses
	localparam logic [4:0] ADR_DATA = 5'h00;
	localparam logic [4:0] ADR_LINE = 5'h04;
	localparam logic [4:0] ADR_ENAB = 5'h08;
	localparam logic [4:0] ADR_FRAME = 5'h0c;
	localparam logic [4:0] ADR_DIVL = 5'h10;
	localparam logic [4:0] ADR_DIVH = 5'h14;
	// line status fields
	localparam int LS_RXC = 7;
	localparam int LS_TXC = 6;
	localparam int LS_EMPTY = 5;
	localparam int LS_FE = 4;
	localparam int LS_DOR = 3;
	localparam int LS_PE = 2;
	localparam int LS_DBL = 1;
	// enable control fields
	localparam int EN_PRR = 7;
	localparam int EN_DIR = 5;
	localparam int EN_RX = 4;
	localparam int EN_TX = 3;
	localparam int EN_CSZ2 = 2;
	localparam int EN_RX8 = 1;
	localparam int EN_TX8 = 0;
	// frame control fields
	localparam int FC_SYNC = 6;
	localparam int FC_PM_HI = 5;
	localparam int FC_PM_LO = 4;
	localparam int FC_SBS = 3;
	localparam int FC_CSZ_HI = 2;
	localparam int FC_CSZ_LO = 1;
	localparam int FC_POL = 0;
	// reset values and widths
	localparam int DIV_W = 12;
	localparam logic [DIV_W-1:0] DIV_RST = 12'h000;
	localparam logic [2:0] CSZ_RST = 3'h3;
	localparam logic [2:0] CSZ_NINE = 3'h7;
	// oversampling: last count and half-bit count per mode
	localparam logic [3:0] OS_NORM_LAST = 4'hf;
	localparam logic [3:0] OS_NORM_HALF = 4'h7;
	localparam logic [3:0] OS_DBL_LAST = 4'h7;
	localparam logic [3:0] OS_DBL_HALF = 4'h3;
	localparam logic [3:0] DATA_MAX = 4'h9;

	// data bits per frame from the char size field
	function automatic logic [3:0] ucf_nbits(input logic [2:0] csz);
		logic [3:0] n;
		n = 4'h8;
		if (csz == CSZ_NINE) begin
			n = 4'h9;
		end else if (csz[2] == 1'b0) begin
			n = {2'b01, csz[1:0]} + 4'h1;
		end
		return n;
	endfunction : ucf_nbits
endpackage : ucf_pkg

//--- hw/ucf_clk_if.sv
// ucf_clk_if: clock strobes passed between the core and its clock helpers
`timescale 1ns/10ps
interface ucf_clk_if;
	logic [11:0] divisor;
	logic reload;
	logic baud_tick;
	logic xck_rise;
	logic xck_fall;
	modport core (output divisor, output reload, input baud_tick, input xck_rise,
		input xck_fall);
	modport gen (input divisor, input reload, output baud_tick);
	modport sync (output xck_rise, output xck_fall);
endinterface : ucf_clk_if

//--- hw/ucf_baud_gen.sv
// ucf_baud_gen: programmable down-counter producing the baud pulse
`timescale 1ns/10ps
module ucf_baud_gen (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// strobes
	ucf_clk_if.gen cif
);
	import ucf_pkg::*;
	typedef struct packed {
		logic [DIV_W-1:0] cnt;
	} ucf_bg_s;
	ucf_bg_s s_q, s_d;

	// one pulse per zero count
	assign cif.baud_tick = (s_q.cnt == '0);

	// count down, reload at zero or on low-byte write
	always_comb begin
		s_d = s_q;
		if (cif.reload || s_q.cnt == '0) begin
			s_d.cnt = cif.divisor;
		end else begin
			s_d.cnt = s_q.cnt - 12'h001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule : ucf_baud_gen

//--- hw/ucf_xck_sync.sv
// ucf_xck_sync: synchroniser and edge detector for the external transfer clock
`timescale 1ns/10ps
module ucf_xck_sync (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// pin and strobes
	input wire logic xck_i,
	ucf_clk_if.sync cif
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} ucf_xs_s;
	ucf_xs_s s_q, s_d;

	// edges from the settled stages only
	assign cif.xck_rise = s_q.s2 & ~s_q.s3;
	assign cif.xck_fall = ~s_q.s2 & s_q.s3;

	// shift chain
	always_comb begin
		s_d = s_q;
		s_d.s1 = xck_i;
		s_d.s2 = s_q.s1;
		s_d.s3 = s_q.s2;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule : ucf_xck_sync

//--- dv/ucf_core_properties.sv
// ucf_core_properties: bus and pin assertions for the serial port core
`timescale 1ns/10ps
module ucf_core_props (
	// watched ports
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic serial_out_pin_o,
	input wire logic transfer_clock_pin_o,
	input wire logic transfer_clock_pin_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// register bus answer timing
	ack_latency_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack missing after request");
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	rdata_upper_a: assert property (ack_o |-> dat_o[31:8] == 24'h0)
		else $error("read data upper bits set");
	rdata_hold_a: assert property (!(cyc_i && stb_i && !ack_o) |=> $stable(dat_o))
		else $error("read data moved without request");
	// pins after reset and on the wire
	reset_idle_a: assert property (disable iff (1'b0) rst_i |=> !ack_o && serial_out_pin_o && !transfer_clock_pin_oe_o)
		else $error("pins not idle after reset");
	start_width_a: assert property ($fell(serial_out_pin_o) |=> !serial_out_pin_o)
		else $error("start bit too short");
	clk_pin_own_a: assert property ($changed(transfer_clock_pin_o) |-> transfer_clock_pin_oe_o || $past(transfer_clock_pin_oe_o))
		else $error("clock pin moved while not driven");
endmodule : ucf_core_props

bind ucf_core ucf_core_props u_ucf_core_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .serial_out_pin_o(serial_out_pin_o),
	.transfer_clock_pin_o(transfer_clock_pin_o), .transfer_clock_pin_oe_o(transfer_clock_pin_oe_o));

//--- dv/ucf_peer.sv
// ucf_peer: remote async serial peer that captures and sends frames
`timescale 1ns/10ps
module ucf_peer (
	// clock
	input wire logic clk_i,
	// serial lines
	input wire logic line_i,
	output logic line_o
);
	int bit_clks = 32;
	int flen = 10;
	logic [15:0] cap_q[$];
	// line rests high when idle
	initial line_o = 1'b1;
	// sample each bit at its middle after the start edge
	initial begin
		logic [15:0] v;
		forever begin
			@(negedge line_i);
			v = 16'h0;
			repeat (bit_clks / 2) @(posedge clk_i);
			for (int i = 0; i < flen; i++) begin
				v[i] = line_i;
				if (i < flen - 1) repeat (bit_clks) @(posedge clk_i);
			end
			cap_q.push_back(v);
		end
	end
	// send one frame lsb first, then rest high
	task automatic send(input logic [15:0] v);
		for (int i = 0; i < flen; i++) begin
			line_o <= v[i];
			repeat (bit_clks) @(posedge clk_i);
		end
		line_o <= 1'b1;
		@(posedge clk_i);
	endtask : send
endmodule : ucf_peer

//--- dv/tb_top.sv
// tb_top: self-checking bench for the serial port core
`timescale 1ns/10ps
module tb_top;
	import ucf_pkg::*;
	localparam int DIV = 1;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [4:0] adr_i = 5'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic ack_o;
	logic sin;
	logic sout;
	logic xck_o;
	logic xck_oe;
	logic xck_i = 1'b0;
	int num_errors = 0;
	int checks = 0;
	// system clock
	always #4 clk_i = ~clk_i;
	ucf_core u_ucf_core (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.serial_in_pin_i(sin), .serial_out_pin_o(sout), .transfer_clock_pin_i(xck_i),
		.transfer_clock_pin_o(xck_o), .transfer_clock_pin_oe_o(xck_oe));
	ucf_peer u_ucf_peer (.clk_i(clk_i), .line_i(sout), .line_o(sin));
	// one classic wishbone cycle, held until ack
	task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d,
		output logic [31:0] q, input logic [3:0] s = 4'hf);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= s;
		dat_i <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (n >= 20) num_errors++;
	endtask : wb
	// compare and count
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// verdict and end of run
	task automatic end_sim();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_sim
	// expected frame bits from start onward, lsb first
	function automatic logic [15:0] frame(input logic [8:0] d, input int nb, input logic [1:0] pm);
		logic [15:0] v;
		logic p;
		v = 16'hffff;
		p = pm[0];
		v[0] = 1'b0;
		for (int i = 0; i < nb; i++) begin
			v[1 + i] = d[i];
			p = p ^ d[i];
		end
		if (pm[1]) v[1 + nb] = p;
		return v;
	endfunction : frame
	// hang guard
	initial begin
		repeat (50000) @(posedge clk_i);
		num_errors++;
		end_sim();
	end
	// main sequence
	initial begin
		logic [31:0] q;
		logic [31:0] m;
		logic [15:0] v;
		logic [8:0] d;
		logic [8:0] d2;
		logic [2:0] csz;
		logic [1:0] pm;
		logic sb;
		logic dbl;
		int nb;
		int e;
		time t0;
		void'($urandom(26));
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk("idle line", 32'h1, 32'(sout));
		chk("clock oe", 32'h0, 32'(xck_oe));
		wb(0, ADR_FRAME, 8'h0, q);
		chk("frame reset", 32'h06, q);
		wb(0, ADR_LINE, 8'h0, q);
		chk("status reset", 32'h20, q);
		wb(1, 5'h18, 8'h5a, q);
		wb(0, 5'h18, 8'h0, q);
		chk("unmapped", 32'h0, q);
		wb(1, ADR_DIVH, 8'h0f, q);
		wb(0, ADR_DIVH, 8'h0, q);
		chk("divisor high", 32'h0f, q);
		wb(1, ADR_DIVL, 8'h33, q, 4'he);
		wb(0, ADR_DIVL, 8'h0, q);
		chk("lane off write", 32'h0, q);
		wb(1, ADR_DIVH, 8'h00, q);
		wb(1, ADR_DIVL, 8'(DIV), q);
		// every size and parity mode, async tx then rx
		for (int t = 0; t < 15; t++) begin
			csz = (t % 5 == 4) ? 3'h7 : 3'(t % 5);
			pm = (t % 3 == 1) ? 2'h3 : 2'(t % 3);
			sb = 1'($urandom);
			dbl = 1'($urandom);
			d = 9'($urandom);
			nb = (csz == 3'h7) ? 9 : int'(csz) + 5;
			m = (32'h1 << (2 + nb + pm[1] + sb)) - 32'h1;
			u_ucf_peer.bit_clks = (dbl ? 8 : 16) * (DIV + 1);
			u_ucf_peer.flen = 2 + nb + pm[1] + sb;
			wb(1, ADR_LINE, {6'h10, dbl, 1'b0}, q);
			wb(1, ADR_FRAME, {2'b00, pm, sb, csz[1:0], 1'b0}, q);
			wb(1, ADR_ENAB, {5'h03, csz[2], 1'b0, d[8]}, q);
			wb(1, ADR_DATA, d[7:0], q);
			for (int n = 0; n < 2000 && u_ucf_peer.cap_q.size() == 0; n++) @(posedge clk_i);
			v = (u_ucf_peer.cap_q.size() > 0) ? u_ucf_peer.cap_q.pop_front() : 16'h0;
			chk("tx frame", 32'(frame(d, nb, pm)) & m, 32'(v));
			d2 = 9'($urandom);
			e = $urandom % 3;
			v = frame(d2, nb, pm);
			if (e == 1 && pm[1]) v[1 + nb] = ~v[1 + nb];
			if (e == 2) v[1 + nb + pm[1]] = 1'b0;
			u_ucf_peer.send(v);
			wb(0, ADR_LINE, 8'h0, q);
			chk("rx status", {24'h0, 3'h7, e == 2, 1'b0, e == 1 && pm[1], dbl, 1'b0}, q);
			wb(0, ADR_ENAB, 8'h0, q);
			if (nb == 9) chk("rx ninth", 32'(d2[8]), 32'(q[EN_RX8]));
			m = (32'h1 << (nb > 8 ? 8 : nb)) - 32'h1;
			wb(0, ADR_DATA, 8'h0, q);
			chk("rx data", 32'(d2[7:0]) & m, q & m);
		end
		// third frame into a full buffer is dropped
		wb(1, ADR_LINE, 8'h00, q);
		wb(1, ADR_ENAB, 8'h18, q);
		wb(1, ADR_FRAME, 8'h06, q);
		u_ucf_peer.bit_clks = 16 * (DIV + 1);
		u_ucf_peer.flen = 10;
		for (int i = 0; i < 3; i++) u_ucf_peer.send(frame(9'(8'h31 + i), 8, 2'b00));
		wb(0, ADR_LINE, 8'h0, q);
		chk("overrun set", 32'h88, q & 32'h88);
		for (int i = 0; i < 2; i++) begin
			wb(0, ADR_DATA, 8'h0, q);
			chk("buffered data", 32'h31 + i, q);
		end
		wb(0, ADR_LINE, 8'h0, q);
		chk("buffer drained", 32'h0, q & 32'h88);
		// synchronous master transmit
		wb(1, ADR_LINE, 8'h40, q);
		wb(1, ADR_FRAME, 8'h46, q);
		wb(1, ADR_ENAB, 8'h28, q);
		@(negedge clk_i);
		chk("master oe", 32'h1, 32'(xck_oe));
		wb(1, ADR_DATA, d[7:0], q);
		wait (sout == 1'b0);
		for (int i = 0; i < 10; i++) begin
			@(negedge xck_o);
			if (i == 0) t0 = $time;
			v[i] = sout;
		end
		chk("sync frame", 32'(frame(d, 8, 2'b00) & 16'h3ff), 32'(v & 16'h3ff));
		chk("sync bit time", 32'(144 * (DIV + 1)), 32'($time - t0));
		q = 32'h0;
		for (int n = 0; n < 40 && q[LS_TXC] !== 1'b1; n++) wb(0, ADR_LINE, 8'h0, q);
		chk("sync tx complete", 32'h1, 32'(q[LS_TXC]));
		wb(1, ADR_FRAME, 8'h06, q);
		@(negedge clk_i);
		chk("async oe", 32'h0, 32'(xck_oe));
		// synchronous slave transmit, polarity set, bench clock at clk over 12
		wb(1, ADR_ENAB, 8'h08, q);
		wb(1, ADR_FRAME, 8'h47, q);
		@(negedge clk_i);
		chk("slave oe", 32'h0, 32'(xck_oe));
		wb(1, ADR_DATA, d2[7:0], q);
		for (int i = 0; i < 11; i++) begin
			repeat (6) @(posedge clk_i);
			xck_i <= 1'b1;
			if (i > 0) v[i - 1] = sout;
			repeat (6) @(posedge clk_i);
			xck_i <= 1'b0;
		end
		chk("slave frame", 32'(frame(d2, 8, 2'b00) & 16'h3ff), 32'(v & 16'h3ff));
		end_sim();
	end
endmodule : tb_top
